// ### verilog/hcd_top.sv
// Purpose: Configuration byte access and decode into device controls
// Assumes: Programming mode and mass erase come from the flash controller
// Notes:   Controls hold the erased value in reset, then load from the store in the boot load
//
// Contract
// - Byte 7F bit 4 enables the 2 kB boot ROM; one is default.
// - Byte 7F bit 3 enables watchdog timeout reset; one is default.
// - Byte 7F bits 2-0 select data flash size; 000 reserved, 111 none.
// - Byte 7E bits 7-6 select digital brownout level, 11 is 2.5 V.
// - Byte 7E bits 5-4 select analog brownout level, same encoding.
// - Byte 7E bit 3 set disables analog brownout detection.
// - Byte 7E bit 2 set disables digital brownout detection.
// - Byte 7E bit 1 zero puts port 0 on the memory bus, strobes on P3.
// - Byte 7E bit 0 zero puts port 2 on the memory bus, strobes on P3.
// - Brownout and watchdog fields change only in programming modes; mass erase sets them to ones in any mode.
// - Byte 7E is reached only through the address and data registers.
// - 128 bytes via SFR 93 and 94; writes only in programming mode.
// - Security bit blocks all changes except mass erase.
module hcd_top (
	input  wire logic             mclk_i,
	input  wire logic             resetn_i,
	input  wire logic             prog_mode_i,
	input  wire logic             mass_erase_i,
	input  wire logic             sfr_wr_i,
	input  wire logic             sfr_rd_i,
	input  wire logic [7:0]       sfr_addr_i,
	input  wire logic [7:0]       sfr_wdata_i,
	output logic      [7:0]       sfr_rdata_o,
	output logic                  cfg_ready_o,
	output hcd_pkg::hcd_ctrl_s    ctrl_o,
	output hcd_pkg::hcd_port_s    port_o
);
	typedef enum logic [1:0]
	{
		LD_IDLE,
		LD_ADDR,
		LD_WAIT,
		LD_DONE
	} hcd_load_e;

	logic                rst_sync1_ff;
	logic                rst_sync2_ff;
	logic                rstn;
	logic                prog_sync1_ff;
	logic                prog_sync2_ff;
	logic                erase_sync1_ff;
	logic                erase_sync2_ff;
	logic [7:0]          addr_ff;
	logic [7:0]          nxt_addr;
	logic [7:0]          data_ff;
	logic [7:0]          nxt_data;
	logic [7:0]          byte_boot_ff;
	logic [7:0]          nxt_byte_boot;
	logic [7:0]          byte_supply_ff;
	logic [7:0]          nxt_byte_supply;
	hcd_load_e           state_ff;
	hcd_load_e           nxt_state;
	logic                rd_pend_ff;
	logic                nxt_rd_pend;
	logic                boot_phase_ff;
	logic                nxt_boot_phase;
	logic                mem_wr;
	logic [6:0]          mem_raddr;
	logic [7:0]          mem_rdata;
	logic                sel_addr;
	logic                sel_data;
	logic                locked;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_sync1_ff <= 1'b0;
			rst_sync2_ff <= 1'b0;
		end
		else
		begin
			rst_sync1_ff <= 1'b1;
			rst_sync2_ff <= rst_sync1_ff;
		end
	end
	assign rstn = rst_sync2_ff;

	always_ff @(posedge mclk_i or negedge rstn)
	begin
		if (!rstn)
		begin
			prog_sync1_ff  <= 1'b0;
			prog_sync2_ff  <= 1'b0;
			erase_sync1_ff <= 1'b0;
			erase_sync2_ff <= 1'b0;
		end
		else
		begin
			prog_sync1_ff  <= prog_mode_i;
			prog_sync2_ff  <= prog_sync1_ff;
			erase_sync1_ff <= mass_erase_i;
			erase_sync2_ff <= erase_sync1_ff;
		end
	end

	function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] target);
		sfr_hit = (a == target);
	endfunction

	assign sel_addr = sfr_hit(sfr_addr_i, hcd_pkg::SFR_CFG_ADDR);
	assign sel_data = sfr_hit(sfr_addr_i, hcd_pkg::SFR_CFG_DATA);
	assign locked   = !byte_boot_ff[hcd_pkg::BIT_SECURITY];
	// Store writes only in programming mode, never while secured
	assign mem_wr   = sfr_wr_i && sel_data && prog_sync2_ff && !locked
		&& !erase_sync2_ff && state_ff == LD_DONE;
	assign mem_raddr = (state_ff == LD_DONE) ? addr_ff[6:0] : hcd_pkg::CFG_SUPPLY_PORT;

	hcd_cfg_mem #(
		.DEPTH(hcd_pkg::CFG_BYTES)
	) hcd_cfg_mem_i (
		.mclk_i    (mclk_i),
		.wr_en_i   (mem_wr),
		.wr_addr_i (addr_ff[6:0]),
		.wr_data_i (sfr_wdata_i),
		.erase_i   (erase_sync2_ff),
		.rd_addr_i (state_ff == LD_WAIT ? hcd_pkg::CFG_BOOT_WDOG : mem_raddr),
		.rd_data_o (mem_rdata)
	);

	always_comb
	begin
		nxt_state       = state_ff;
		nxt_byte_boot   = byte_boot_ff;
		nxt_byte_supply = byte_supply_ff;
		nxt_addr        = addr_ff;
		nxt_data        = data_ff;
		nxt_rd_pend     = 1'b0;
		unique case (state_ff)
			LD_IDLE:
				nxt_state = LD_ADDR;
			LD_ADDR:
				nxt_state = LD_WAIT;
			LD_WAIT:
			begin
				nxt_byte_supply = mem_rdata;
				nxt_state       = LD_DONE;
			end
			LD_DONE:
				nxt_state = LD_DONE;
		endcase
		// Boot byte arrives from the store one cycle after the supply byte
		nxt_boot_phase = (state_ff == LD_WAIT);
		if (boot_phase_ff)
			nxt_byte_boot = mem_rdata;
		if (state_ff == LD_DONE)
		begin
			if (sfr_wr_i && sel_addr)
				nxt_addr = {1'b0, sfr_wdata_i[6:0]};
			if (sfr_wr_i && sel_data)
				nxt_data = sfr_wdata_i;
			if (sfr_rd_i && sel_data)
				nxt_rd_pend = 1'b1;
			if (rd_pend_ff)
				nxt_data = mem_rdata;
		end
		if (state_ff == LD_DONE && erase_sync2_ff)
			nxt_state = LD_IDLE;
	end

	always_ff @(posedge mclk_i or negedge rstn)
	begin
		if (!rstn)
		begin
			state_ff       <= LD_IDLE;
			byte_supply_ff <= hcd_pkg::ERASED_BYTE;
			byte_boot_ff   <= hcd_pkg::ERASED_BYTE;
			boot_phase_ff  <= 1'b0;
			addr_ff        <= hcd_pkg::SFR_RESET_VALUE;
			data_ff        <= hcd_pkg::SFR_RESET_VALUE;
			rd_pend_ff     <= 1'b0;
		end
		else
		begin
			state_ff       <= nxt_state;
			byte_supply_ff <= nxt_byte_supply;
			byte_boot_ff   <= nxt_byte_boot;
			boot_phase_ff  <= nxt_boot_phase;
			addr_ff        <= nxt_addr;
			data_ff        <= nxt_data;
			rd_pend_ff     <= nxt_rd_pend;
		end
	end

	assign cfg_ready_o = (state_ff == LD_DONE) && !boot_phase_ff;
	assign sfr_rdata_o = data_ff;

	always_comb
	begin
		ctrl_o.boot_rom_enable          = byte_boot_ff[hcd_pkg::BIT_BOOT_ROM];
		ctrl_o.watchdog_reset_enable    = byte_boot_ff[hcd_pkg::BIT_WDOG_RESET];
		ctrl_o.data_flash_size_sel      = byte_boot_ff[hcd_pkg::LSB_FLASH_SIZE +: 3];
		ctrl_o.digital_brownout_level   =
			hcd_pkg::hcd_level_e'(byte_supply_ff[hcd_pkg::LSB_DIG_LEVEL +: 2]);
		ctrl_o.analog_brownout_level    =
			hcd_pkg::hcd_level_e'(byte_supply_ff[hcd_pkg::LSB_ANA_LEVEL +: 2]);
		ctrl_o.analog_brownout_disable  = byte_supply_ff[hcd_pkg::BIT_ANA_DISABLE];
		ctrl_o.digital_brownout_disable = byte_supply_ff[hcd_pkg::BIT_DIG_DISABLE];
		ctrl_o.port0_gpio_select        = byte_supply_ff[hcd_pkg::BIT_PORT0_GPIO];
		ctrl_o.port23_gpio_select       = byte_supply_ff[hcd_pkg::BIT_PORT23_GPIO];
		ctrl_o.security_access_bit      = byte_boot_ff[hcd_pkg::BIT_SECURITY];
		port_o.ext_mem_port0            = !byte_supply_ff[hcd_pkg::BIT_PORT0_GPIO];
		port_o.ext_mem_port2            = !byte_supply_ff[hcd_pkg::BIT_PORT23_GPIO];
		port_o.port3_strobes            = !byte_supply_ff[hcd_pkg::BIT_PORT0_GPIO]
			|| !byte_supply_ff[hcd_pkg::BIT_PORT23_GPIO];
		port_o.flash_size_reserved      = (byte_boot_ff[2:0] == 3'h0);
		port_o.data_flash_none          = (byte_boot_ff[2:0] == 3'h7);
	end

	property p_no_write_outside_prog;
		@(posedge mclk_i) disable iff (!rstn)
		!prog_sync2_ff |-> !mem_wr;
	endproperty
	AST_WRITE_ONLY_PROG: assert property (p_no_write_outside_prog)
		else $error("config write outside programming mode");

	AST_LOCK_BLOCKS: assert property (@(posedge mclk_i) disable iff (!rstn)
		locked |-> !mem_wr)
		else $error("config write while secured");

	sequence s_load;
		state_ff == LD_WAIT ##1 boot_phase_ff;
	endsequence
	// An erase seen in LD_DONE restarts the load; a boot byte already being fetched is still captured that cycle
	AST_LOAD_SEQ: assert property (@(posedge mclk_i) disable iff (!rstn || erase_sync2_ff)
		state_ff == LD_IDLE && !erase_sync2_ff |-> ##2 s_load ##1 cfg_ready_o)
		else $error("control load sequence wrong");

	AST_PORT3_STROBE: assert property (@(posedge mclk_i) disable iff (!rstn)
		port_o.port3_strobes == (port_o.ext_mem_port0 || port_o.ext_mem_port2))
		else $error("port 3 strobe select mismatch");

	AST_SUPPLY_STABLE: assert property (@(posedge mclk_i) disable iff (!rstn)
		cfg_ready_o && $past(cfg_ready_o) |-> $stable(byte_supply_ff))
		else $error("supply controls changed at run time");

	AST_DATA_READ: assert property (@(posedge mclk_i) disable iff (!rstn)
		cfg_ready_o && sfr_rd_i && sel_data |-> ##2 sfr_rdata_o == $past(mem_rdata, 1))
		else $error("data register read wrong");
endmodule

// ### verilog/hcd_pkg.sv
// Purpose: Constants and carrier types for the configuration byte block
// Assumes: 128 configuration bytes, SFR window at 93/94
// Notes:   Erased flash reads all ones
package hcd_pkg;
	localparam logic [7:0] SFR_CFG_ADDR     = 8'h93;
	localparam logic [7:0] SFR_CFG_DATA     = 8'h94;
	localparam logic [6:0] CFG_SUPPLY_PORT  = 7'h7E;
	localparam logic [6:0] CFG_BOOT_WDOG    = 7'h7F;
	localparam int         CFG_BYTES        = 128;
	localparam logic [7:0] ERASED_BYTE      = 8'hFF;
	localparam logic [7:0] SFR_RESET_VALUE  = 8'h00;
	localparam int         BIT_SECURITY     = 7;
	localparam int         BIT_BOOT_ROM     = 4;
	localparam int         BIT_WDOG_RESET   = 3;
	localparam int         LSB_FLASH_SIZE   = 0;
	localparam int         LSB_DIG_LEVEL    = 6;
	localparam int         LSB_ANA_LEVEL    = 4;
	localparam int         BIT_ANA_DISABLE  = 3;
	localparam int         BIT_DIG_DISABLE  = 2;
	localparam int         BIT_PORT0_GPIO   = 1;
	localparam int         BIT_PORT23_GPIO  = 0;
	localparam logic [6:0] LOAD_LAST        = 7'h7F;

	typedef enum logic [1:0]
	{
		HCD_LVL_4V5,
		HCD_LVL_4V2,
		HCD_LVL_2V7,
		HCD_LVL_2V5
	} hcd_level_e;

	typedef struct packed
	{
		logic       boot_rom_enable;
		logic       watchdog_reset_enable;
		logic [2:0] data_flash_size_sel;
		hcd_level_e digital_brownout_level;
		hcd_level_e analog_brownout_level;
		logic       analog_brownout_disable;
		logic       digital_brownout_disable;
		logic       port0_gpio_select;
		logic       port23_gpio_select;
		logic       security_access_bit;
	} hcd_ctrl_s;

	typedef struct packed
	{
		logic       ext_mem_port0;
		logic       ext_mem_port2;
		logic       port3_strobes;
		logic       flash_size_reserved;
		logic       data_flash_none;
	} hcd_port_s;
endpackage

// ### verilog/hcd_cfg_mem.sv
// Purpose: Nonvolatile store for the 128 configuration bytes
// Assumes: One read and one write per cycle, registered read data
// Notes:   Contents model erased flash until written
module hcd_cfg_mem #(
	parameter int DEPTH = 128
) (
	input  wire logic       mclk_i,
	input  wire logic       wr_en_i,
	input  wire logic [6:0] wr_addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       erase_i,
	input  wire logic [6:0] rd_addr_i,
	output logic      [7:0] rd_data_o
);
	// Erased contents at power-up and on erase_i; no reset touches the store
	logic [7:0] mem_ff [DEPTH] = '{default: hcd_pkg::ERASED_BYTE};
	logic [7:0] rd_data_ff;

	always_ff @(posedge mclk_i)
	begin
		for (int i = 0; i < DEPTH; i++)
		begin
			if (erase_i)
				mem_ff[i] <= hcd_pkg::ERASED_BYTE;
			else if (wr_en_i && wr_addr_i == 7'(i))
				mem_ff[i] <= wr_data_i;
		end
		rd_data_ff <= mem_ff[rd_addr_i];
	end

	assign rd_data_o = rd_data_ff;
endmodule

// ### bench/hcd_top_test.sv
// Purpose: Self-checking bench for the configuration byte block
// Assumes: Store starts erased; reads answer within three edges
// Notes:   Read results are scored from a queue by a monitor process
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module hcd_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic               mclk_i;
	logic               resetn_i = 1'b0;
	logic               prog_mode_i = 1'b0;
	logic               mass_erase_i = 1'b0;
	logic               sfr_wr_i = 1'b0;
	logic               sfr_rd_i = 1'b0;
	logic [7:0]         sfr_addr_i = 8'h00;
	logic [7:0]         sfr_wdata_i = 8'h00;
	logic [7:0]         sfr_rdata_o;
	logic               cfg_ready_o;
	hcd_pkg::hcd_ctrl_s ctrl_o;
	hcd_pkg::hcd_port_s port_o;
	logic [7:0]         exp_q[$];
	logic [7:0]         exp_rd;
	logic [2:0]         rd_d = 3'h0;
	logic [7:0]         cur_7e = 8'hFF;
	logic [7:0]         cur_7f = 8'hFF;
	int                 error_cnt = 0;
	int                 n_tests = 0;

	hcd_top hcd_top_i (
		.mclk_i      (mclk_i),
		.resetn_i    (resetn_i),
		.prog_mode_i (prog_mode_i),
		.mass_erase_i(mass_erase_i),
		.sfr_wr_i    (sfr_wr_i),
		.sfr_rd_i    (sfr_rd_i),
		.sfr_addr_i  (sfr_addr_i),
		.sfr_wdata_i (sfr_wdata_i),
		.sfr_rdata_o (sfr_rdata_o),
		.cfg_ready_o (cfg_ready_o),
		.ctrl_o      (ctrl_o),
		.port_o      (port_o)
	);

	initial
	begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end

	// Monitor: score each data read once its answer stands
	always @(posedge mclk_i)
	begin
		rd_d <= {rd_d[1:0], sfr_rd_i && sfr_addr_i == hcd_pkg::SFR_CFG_DATA};
	end
	always @(negedge mclk_i)
	begin
		if (rd_d[2])
		begin
			exp_rd = exp_q.pop_front();
			`CHK("sfr_rdata_o", exp_rd, sfr_rdata_o)
		end
	end

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		sfr_wr_i = wr;
		sfr_rd_i = !wr;
		sfr_addr_i = a;
		sfr_wdata_i = d;
		@(negedge mclk_i);
		sfr_wr_i = 1'b0;
		sfr_rd_i = 1'b0;
	endtask

	task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
		sfr(1'b1, hcd_pkg::SFR_CFG_ADDR, a);
		sfr(1'b1, hcd_pkg::SFR_CFG_DATA, d);
	endtask

	task automatic cfg_rd(input logic [7:0] a, input logic [7:0] ex);
		sfr(1'b1, hcd_pkg::SFR_CFG_ADDR, a);
		exp_q.push_back(ex);
		sfr(1'b0, hcd_pkg::SFR_CFG_DATA, 8'h00);
		repeat (4) @(negedge mclk_i);
	endtask

	task automatic wait_ready();
		int i;
		for (i = 0; i < 50 && cfg_ready_o !== 1'b1; i++)
			@(negedge mclk_i);
		`CHK("cfg_ready_o", 1'b1, cfg_ready_o)
	endtask

	task automatic do_reset();
		@(negedge mclk_i);
		resetn_i = 1'b0;
		repeat (10) @(negedge mclk_i);
		`CHK("cfg_ready_o", 1'b0, cfg_ready_o)
		`CHK("sfr_rdata_o", 8'h00, sfr_rdata_o)
		resetn_i = 1'b1;
		wait_ready();
	endtask

	// Decode expected from the stored bytes
	task automatic chk_ctrl();
		hcd_pkg::hcd_ctrl_s ec;
		hcd_pkg::hcd_port_s ep;
		ec.boot_rom_enable = cur_7f[4];
		ec.watchdog_reset_enable = cur_7f[3];
		ec.data_flash_size_sel = cur_7f[2:0];
		ec.digital_brownout_level = hcd_pkg::hcd_level_e'(cur_7e[7:6]);
		ec.analog_brownout_level = hcd_pkg::hcd_level_e'(cur_7e[5:4]);
		ec.analog_brownout_disable = cur_7e[3];
		ec.digital_brownout_disable = cur_7e[2];
		ec.port0_gpio_select = cur_7e[1];
		ec.port23_gpio_select = cur_7e[0];
		ec.security_access_bit = cur_7f[7];
		ep.ext_mem_port0 = !cur_7e[1];
		ep.ext_mem_port2 = !cur_7e[0];
		ep.port3_strobes = !cur_7e[1] || !cur_7e[0];
		ep.flash_size_reserved = cur_7f[2:0] == 3'h0;
		ep.data_flash_none = cur_7f[2:0] == 3'h7;
		`CHK("ctrl_o", ec, ctrl_o)
		`CHK("port_o", ep, port_o)
	endtask

	initial
	begin
		#(20000 * 50);
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		void'($urandom(54));
		repeat (10) @(negedge mclk_i);
		resetn_i = 1'b1;
		wait_ready();
		chk_ctrl();
		`CHK("sfr_rdata_o", 8'h00, sfr_rdata_o)
		cfg_rd(8'h7E, cur_7e);
		cfg_rd(8'h7F, cur_7f);
		cfg_rd(8'h05, 8'hFF);
		cfg_wr(8'h7E, 8'h00);
		cfg_rd(8'h7E, cur_7e);
		prog_mode_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		for (int k = 0; k < 8; k++)
		begin
			cur_7e = {k[1:0], k[2:1], 4'($urandom)};
			cur_7f = {1'b1, 4'($urandom), k[2:0]};
			cfg_wr(8'h7E, cur_7e);
			cfg_wr(8'h7F, cur_7f);
			cfg_rd(8'hFE, cur_7e);
			cfg_rd(8'h7F, cur_7f);
			do_reset();
			chk_ctrl();
		end
		cur_7f = {1'b0, cur_7f[6:0]};
		cfg_wr(8'h7F, cur_7f);
		do_reset();
		chk_ctrl();
		cfg_wr(8'h7E, ~cur_7e);
		prog_mode_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		cfg_rd(8'h7E, cur_7e);
		mass_erase_i = 1'b1;
		repeat (5) @(negedge mclk_i);
		mass_erase_i = 1'b0;
		cur_7e = 8'hFF;
		cur_7f = 8'hFF;
		repeat (4) @(negedge mclk_i);
		wait_ready();
		chk_ctrl();
		cfg_rd(8'h7E, 8'hFF);
		give_verdict();
	end
endmodule
